// ### cdsel_top.sv
// clock divider with core, peripheral and bus ratio selection
`timescale 1ns/1ps
module cdsel_top
    import cdsel_pkg::*;
(
    input  wire logic                    CLK_SYS_IN,
    input  wire logic                    RST_IN,
    input  wire logic [3:0]              ADDR_IN,
    input  wire logic [CDSEL_DATA_W-1:0] WDATA_IN,
    input  wire logic                    WR_IN,
    input  wire logic                    RD_IN,
    input  wire logic                    BUS_CYCLE_BUSY_IN,
    output logic [CDSEL_DATA_W-1:0]      RDATA_OUT,
    output logic                         CORE_CLK_EN_OUT,
    output logic                         PERIPH_CLK_EN_OUT,
    output logic                         BUS_CLK_EN_OUT,
    output logic                         XFER_CLK_EN_OUT,
    output logic                         INPUT_PHASE_OUT
);
    // CLK_SYS_IN stands for the multiplied clock; each derived clock is an enable on it
    cdsel_ratio_t               written_r;
    cdsel_ratio_t               active_r;
    cdsel_ratio_t               eff;
    cdsel_state_t               state_r;
    logic [CDSEL_DIV_W-1:0]     div_r;
    logic                       pending_r;
    logic                       core_en;
    logic                       periph_en;
    logic                       bus_en;

    // pick the enable for a ratio code off the free-running divider
    function automatic logic ratio_en(input logic [2:0] code, input logic [CDSEL_DIV_W-1:0] d);
        logic en;
        en = 1'b0;
        unique case (code)
            CDSEL_RATIO_X4:   en = 1'b1;
            CDSEL_RATIO_X2:   en = (d[0] == 1'b1);
            CDSEL_RATIO_X1:   en = (d[1:0] == 2'h3);
            CDSEL_RATIO_HALF: en = (d == 3'h7);
            default:          en = 1'b0;
        endcase
        return en;
    endfunction : ratio_en

    // keep the old field when the new code is prohibited
    function automatic logic [2:0] keep_valid(input logic [2:0] nw, input logic [2:0] old);
        return nw[2] ? old : nw;
    endfunction : keep_valid

    // clamp to the core ratio: larger code is slower
    function automatic logic [2:0] clamp(input logic [2:0] own, input logic [2:0] core);
        return (own < core) ? core : own;
    endfunction : clamp

    // divider of the multiplied clock; wraps every eight cycles, two input clock periods
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            div_r <= '0;                                          // phase zero aligned with input edge
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    // software image of the control register, prohibited codes filtered on write
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            written_r.core   <= CDSEL_CTRL_RESET[CDSEL_CORE_LSB +: CDSEL_FIELD_W];
            written_r.periph <= CDSEL_CTRL_RESET[CDSEL_PERIPH_LSB +: CDSEL_FIELD_W];
            written_r.bus    <= CDSEL_CTRL_RESET[CDSEL_BUS_LSB +: CDSEL_FIELD_W];
        end else if (WR_IN && ADDR_IN == CDSEL_CTRL_OFFSET) begin
            written_r.core   <= keep_valid(WDATA_IN[CDSEL_CORE_LSB +: CDSEL_FIELD_W], written_r.core);
            written_r.periph <= keep_valid(WDATA_IN[CDSEL_PERIPH_LSB +: CDSEL_FIELD_W], written_r.periph);
            written_r.bus    <= keep_valid(WDATA_IN[CDSEL_BUS_LSB +: CDSEL_FIELD_W], written_r.bus);
        end
    end

    // switch sequencer: wait for bus idle, then for the next input-clock rising edge
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            state_r   <= CDSEL_IDLE;
            pending_r <= 1'b0;
        end else begin
            unique case (state_r)
                CDSEL_IDLE: begin
                    if (WR_IN && ADDR_IN == CDSEL_CTRL_OFFSET) begin
                        state_r   <= CDSEL_WAIT_BUS;
                        pending_r <= 1'b1;
                    end
                end
                CDSEL_WAIT_BUS: begin
                    if (!BUS_CYCLE_BUSY_IN) begin
                        state_r <= CDSEL_WAIT_ALIGN;              // current bus cycle has ended
                    end
                end
                CDSEL_WAIT_ALIGN: begin
                    // at most four multiplied cycles, one input clock cycle
                    if (div_r[1:0] == 2'h3) begin
                        // a write landing on the load edge misses this load, so start another switch
                        if (WR_IN && ADDR_IN == CDSEL_CTRL_OFFSET) begin
                            state_r   <= CDSEL_WAIT_BUS;
                            pending_r <= 1'b1;
                        end else begin
                            state_r   <= CDSEL_IDLE;
                            pending_r <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_r   <= CDSEL_IDLE;
                    pending_r <= 1'b0;
                end
            endcase
        end
    end

    // active ratios load on an input-clock boundary so no glitch reaches a module
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            active_r.core   <= CDSEL_CTRL_RESET[CDSEL_CORE_LSB +: CDSEL_FIELD_W];
            active_r.periph <= CDSEL_CTRL_RESET[CDSEL_PERIPH_LSB +: CDSEL_FIELD_W];
            active_r.bus    <= CDSEL_CTRL_RESET[CDSEL_BUS_LSB +: CDSEL_FIELD_W];
        end else if (state_r == CDSEL_WAIT_ALIGN && div_r[1:0] == 2'h3) begin
            active_r <= written_r;
        end
    end

    // effective ratios after the core clamp
    always_comb begin
        eff.core   = active_r.core;
        eff.periph = clamp(active_r.periph, active_r.core);
        eff.bus    = clamp(active_r.bus, active_r.core);
        core_en    = ratio_en(eff.core, div_r);
        periph_en  = ratio_en(eff.periph, div_r);
        bus_en     = ratio_en(eff.bus, div_r);
    end

    // enables registered so every output comes from a flip-flop
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            CORE_CLK_EN_OUT   <= 1'b0;
            PERIPH_CLK_EN_OUT <= 1'b0;
            BUS_CLK_EN_OUT    <= 1'b0;
            XFER_CLK_EN_OUT   <= 1'b0;
            INPUT_PHASE_OUT   <= 1'b0;
        end else begin
            CORE_CLK_EN_OUT   <= core_en;
            PERIPH_CLK_EN_OUT <= periph_en;                       // peripherals run on this
            BUS_CLK_EN_OUT    <= bus_en;
            XFER_CLK_EN_OUT   <= core_en;                         // transfer controller on core clock
            INPUT_PHASE_OUT   <= (div_r[1:0] == 2'h3);            // one pulse per input clock
        end
    end

    // read data one cycle after the strobe; reserved bits read zero
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= '0;
        end else if (RD_IN && ADDR_IN == CDSEL_CTRL_OFFSET) begin
            RDATA_OUT <= {5'h00, written_r.core, 1'b0, written_r.periph, 1'b0, written_r.bus};
        end else if (RD_IN && ADDR_IN == CDSEL_STAT_OFFSET) begin
            // status: switch pending plus the ratios in force after clamping
            RDATA_OUT <= {pending_r, 4'h0, eff.core, 1'b0, eff.periph, 1'b0, eff.bus};
        end else begin
            RDATA_OUT <= '0;                                      // unmapped or no read
        end
    end
endmodule : cdsel_top

// ### cdsel_pkg.sv
// package for the clock divider and ratio select block
package cdsel_pkg;
    // register offset, width and layout of the clock division control word
    localparam logic [3:0]  CDSEL_CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  CDSEL_STAT_OFFSET   = 4'h2;
    localparam int          CDSEL_DATA_W        = 16;
    localparam logic [15:0] CDSEL_CTRL_RESET    = 16'h0222;
    localparam logic [15:0] CDSEL_CTRL_WMASK    = 16'h0777;
    localparam int          CDSEL_CORE_LSB      = 8;
    localparam int          CDSEL_PERIPH_LSB    = 4;
    localparam int          CDSEL_BUS_LSB       = 0;
    localparam int          CDSEL_FIELD_W       = 3;
    // ratio codes: smaller code means faster clock
    localparam logic [2:0]  CDSEL_RATIO_X4      = 3'h0;
    localparam logic [2:0]  CDSEL_RATIO_X2      = 3'h1;
    localparam logic [2:0]  CDSEL_RATIO_X1      = 3'h2;
    localparam logic [2:0]  CDSEL_RATIO_HALF    = 3'h3;
    localparam int          CDSEL_PLL_FACTOR    = 4;
    localparam int          CDSEL_DIV_W         = 3;
    // worst-case switch time: one input clock cycle = four multiplied cycles
    localparam int          CDSEL_SWITCH_MAX    = CDSEL_PLL_FACTOR;

    typedef struct packed {
        logic [2:0] core;
        logic [2:0] periph;
        logic [2:0] bus;
    } cdsel_ratio_t;

    typedef enum logic [1:0] {
        CDSEL_IDLE,
        CDSEL_WAIT_BUS,
        CDSEL_WAIT_ALIGN
    } cdsel_state_t;
endpackage : cdsel_pkg

// ### cdsel_props.sv
// checker for the clock divider and ratio select block
`timescale 1ns/1ps
module cdsel_props
    import cdsel_pkg::*;
(
    input wire logic                    CLK_SYS_IN,
    input wire logic                    RST_IN,
    input wire logic [3:0]              ADDR_IN,
    input wire logic [CDSEL_DATA_W-1:0] WDATA_IN,
    input wire logic                    WR_IN,
    input wire logic                    RD_IN,
    input wire logic                    BUS_CYCLE_BUSY_IN,
    input wire logic [CDSEL_DATA_W-1:0] RDATA_OUT,
    input wire logic                    CORE_CLK_EN_OUT,
    input wire logic                    PERIPH_CLK_EN_OUT,
    input wire logic                    BUS_CLK_EN_OUT,
    input wire logic                    XFER_CLK_EN_OUT,
    input wire logic                    INPUT_PHASE_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    // a control write made while the external bus is still busy
    sequence wr_busy_s; WR_IN && ADDR_IN == 4'h0 && BUS_CYCLE_BUSY_IN; endsequence
    sequence rd_stat_s; BUS_CYCLE_BUSY_IN && RD_IN && ADDR_IN == 4'h2; endsequence
    rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 16'h0) else $error("read data without read");
    reserved_zero_a: assert property (RD_IN && ADDR_IN == 4'h0 |=> (RDATA_OUT & 16'hfccc) == 16'h0)
        else $error("control readback holds reserved or prohibited bits");
    unmapped_rd_a: assert property (RD_IN && ADDR_IN != 4'h0 && ADDR_IN != 4'h2 |=> RDATA_OUT == 16'h0)
        else $error("unmapped read not zero");
    phase_period_a: assert property (INPUT_PHASE_OUT |=> !INPUT_PHASE_OUT [*3] ##1 INPUT_PHASE_OUT)
        else $error("input phase marker not every fourth cycle");
    periph_clamp_a: assert property (PERIPH_CLK_EN_OUT |-> CORE_CLK_EN_OUT) else $error("periph faster");
    bus_clamp_a: assert property (BUS_CLK_EN_OUT |-> CORE_CLK_EN_OUT) else $error("bus faster than core");
    xfer_core_a: assert property (XFER_CLK_EN_OUT == CORE_CLK_EN_OUT) else $error("xfer enable off core");
    core_gap_a: assert property (CORE_CLK_EN_OUT |-> ##[1:8] CORE_CLK_EN_OUT) else $error("core gap over 8");
    pending_flag_a: assert property (wr_busy_s ##2 rd_stat_s |=> RDATA_OUT[15])
        else $error("switch pending flag missing while bus busy");
endmodule : cdsel_props

// ### test_clock_divider_select.sv
// self-checking bench for the clock divider and ratio select block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_clock_divider_select;
    import cdsel_pkg::*;
    logic clk, rst, wr, rd, busy;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic core_en, per_en, bus_en;
    int miscompares = 0, check_count = 0, cyc = 0;
    cdsel_top cdsel_top_i (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .BUS_CYCLE_BUSY_IN(busy), .RDATA_OUT(rdata), .CORE_CLK_EN_OUT(core_en),
        .PERIPH_CLK_EN_OUT(per_en), .BUS_CLK_EN_OUT(bus_en), .XFER_CLK_EN_OUT(), .INPUT_PHASE_OUT());
    // 50 ns period clock
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // hang guard: every test finishes well inside this budget
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe, sampled mid-cycle
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        @(negedge clk); `CHK(rdata, e)
    endtask : rd_reg
    // cycles between two enable pulses of clock s (0 core, 1 periph, 2 bus)
    task automatic period(input int s, input int e);
        int n;
        n = 0;
        repeat (8) @(posedge clk);
        do @(negedge clk); while (!(s == 0 ? core_en : s == 1 ? per_en : bus_en) && ++n < 20);
        n = 0;
        do begin @(negedge clk); n++; end while (!(s == 0 ? core_en : s == 1 ? per_en : bus_en) && n < 20);
        `CHK(n, e)
    endtask : period
    task automatic t_reset();
        rd_reg(4'h0, CDSEL_CTRL_RESET);
        period(2, 4);
        $display("reset test done");
    endtask : t_reset
    task automatic t_ratios();
        // core kept at x4 from the 8 MHz floor upward, inside the legal range
        for (int c = 0; c < 4; c++) begin
            wr_reg(4'h0, {9'h0, c[2:0], 1'b0, c[2:0]});
            period(1, 1 << c);
            period(2, 1 << c);
        end
        period(0, 1);
        $display("ratio test done");
    endtask : t_ratios
    task automatic t_busy();
        busy <= 1'b1;
        wr_reg(4'h0, 16'h0000);
        rd_reg(4'h2, 16'h8033);
        period(2, 8);
        rd_reg(4'h2, 16'h8033);
        busy <= 1'b0;
        period(2, 1);
        $display("bus busy test done");
    endtask : t_busy
    task automatic t_clamp();
        wr_reg(4'h0, 16'h0310);
        period(2, 8);
        period(1, 8);
        wr_reg(4'h0, 16'h0741);
        rd_reg(4'h0, 16'h0311);
        period(0, 8);
        wr_reg(4'h5, 16'h0000);
        rd_reg(4'h5, 16'h0000);
        rd_reg(4'h0, 16'h0311);
        $display("clamp test done");
    endtask : t_clamp
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; busy = 1'b0; addr = 4'h0; wdata = 16'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ratios();
        t_busy();
        t_clamp();
        summarize();
    end
endmodule : test_clock_divider_select
bind cdsel_top cdsel_props cdsel_props_i (.*);
